/* File: design/mcu_fetch_sequencer.sv */
// Overview of operation
// - Four non-overlapping phase clocks; one full round is one instruction cycle.
// - Counter advances at first phase start; fetch then; later phases execute.
// - Fetch of next overlaps execute of current; one instruction per cycle.
// - Counter-changing instructions take two instruction cycles.
// - Ten-bit counter, two high plus eight low, increments unless branching.
// - Only low byte is software accessible; writing it jumps inside page.
// - Writing the low byte inserts one dummy cycle for prefetch.
// - Met skip condition discards prefetched instruction, runs dummy cycle.
// - Jumps, calls, interrupts and reset load target address directly.
// - Two-entry return stack, invisible to software, pointer too.
// - Call or interrupt acknowledge pushes; either return pops.
// - Reset leaves stack pointer at top, stack empty.
// - Full stack: latch enabled interrupt flag, hold acknowledge until a return.
// - Call with full stack still executes and overflows.
// - Eight-bit ALU writes result and updates carry and condition status.
// - ALU: add, subtract, carry forms, decimal adjust, logic, rotates, inc, dec.
// - Program memory is 1024 words of 14 bits addressed by counter.
// - Table data addressed by separate table pointer register.
// - Each table read takes two instruction cycles.
// - Table read gives low byte to data register, high six bits to table high byte register.
// - Taken interrupt branches to its own vector: edge, timer, conversion.
`timescale 1ns/1ps
`default_nettype none

module mcu_fetch_sequencer (
    input wire logic CORE_CLK, // 25 MHz core clock
    input wire logic ARST_N, // Asynchronous reset, active low
    input wire fetch_seq_pkg::bus_req_s BUS_REQ, // Register port request
    output logic [7:0] RDATA, // Read data, cycle after the read strobe
    output logic [9:0] PM_ADDR, // Program memory word address
    input wire logic [13:0] PM_DATA, // Program memory word
    input wire logic [2:0] IRQ, // Request pulses: edge, timer, conversion
    output logic INT_ACK, // Interrupt acknowledge pulse
    output logic [3:0] PHASE_CLOCKS // One-hot phase clocks, bit 0 is fetch phase
);

    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] phase_clk;
        logic [9:0] pc;
        logic [9:0] pm_addr;
        logic [13:0] ir;
        logic ir_dummy;
        logic tbl_stall;
        logic [9:0] stk0;
        logic [9:0] stk1;
        logic [1:0] depth;
        logic [7:0] acc;
        logic [3:0] status;
        logic [7:0] tblp;
        logic [5:0] table_high_byte;
        logic [3:0] ctrl;
        logic gie;
        logic [2:0] iflag;
        logic pcl_pend;
        logic [7:0] pcl_val;
        logic [7:0] rdata;
        logic int_ack;
    } core_s;

    core_s s_q;
    core_s s_d;

    function automatic fetch_seq_pkg::alu_out_s alu(input logic [3:0] fn, input logic [7:0] a,
                                                     input logic [7:0] b, input logic [3:0] st);
        logic [8:0] sum;
        logic [4:0] nib;
        logic [8:0] adj;
        fetch_seq_pkg::alu_out_s o;
        sum = 9'h000;
        nib = 5'h00;
        adj = 9'h000;
        o.res = a;
        o.status = st;
        unique case (fn)
            fetch_seq_pkg::AF_ADD, fetch_seq_pkg::AF_ADC, fetch_seq_pkg::AF_SUB,
            fetch_seq_pkg::AF_SBC:
            begin
                // Subtract is add of the complement; carry set means no borrow
                logic [7:0] bb;
                logic cin;
                bb = fn[1] ? ~b : b;
                cin = fn[0] ? st[fetch_seq_pkg::ST_C] : fn[1];
                sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
                nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
                o.res = sum[7:0];
                o.status[fetch_seq_pkg::ST_C] = sum[8];
                o.status[fetch_seq_pkg::ST_AC] = nib[4];
                o.status[fetch_seq_pkg::ST_OV] = (a[7] == bb[7]) && (sum[7] != a[7]);
            end
            fetch_seq_pkg::AF_DAA:
            begin
                adj = {1'b0, a};
                if (st[fetch_seq_pkg::ST_AC] || (a[3:0] > 4'h9))
                begin
                    adj = adj + 9'h006;
                end
                if (st[fetch_seq_pkg::ST_C] || (adj[8:4] > 5'h09))
                begin
                    adj = adj + 9'h060;
                end
                o.res = adj[7:0];
                o.status[fetch_seq_pkg::ST_C] = st[fetch_seq_pkg::ST_C] | adj[8];
            end
            fetch_seq_pkg::AF_AND: o.res = a & b;
            fetch_seq_pkg::AF_OR: o.res = a | b;
            fetch_seq_pkg::AF_XOR: o.res = a ^ b;
            fetch_seq_pkg::AF_CPL: o.res = ~a;
            fetch_seq_pkg::AF_RR: o.res = {a[0], a[7:1]};
            fetch_seq_pkg::AF_RRC:
            begin
                o.res = {st[fetch_seq_pkg::ST_C], a[7:1]};
                o.status[fetch_seq_pkg::ST_C] = a[0];
            end
            fetch_seq_pkg::AF_RL: o.res = {a[6:0], a[7]};
            fetch_seq_pkg::AF_RLC:
            begin
                o.res = {a[6:0], st[fetch_seq_pkg::ST_C]};
                o.status[fetch_seq_pkg::ST_C] = a[7];
            end
            fetch_seq_pkg::AF_INC: o.res = a + 8'h01;
            fetch_seq_pkg::AF_DEC: o.res = a - 8'h01;
            fetch_seq_pkg::AF_MOV: o.res = b;
        endcase
        o.status[fetch_seq_pkg::ST_Z] = (o.res == 8'h00);
        return o;
    endfunction : alu

    logic bd;
    logic run;
    logic [2:0] ien_hit;
    logic take_int;
    logic exec;
    logic [1:0] cls;
    logic [3:0] fn;
    logic is_branch;
    logic is_skip;
    logic is_tbl;
    logic is_ret;
    logic is_call;
    logic is_alu;

    assign bd = (s_q.phase == 2'h3);
    assign run = s_q.ctrl[fetch_seq_pkg::CTRL_RUN_BIT];
    assign ien_hit = s_q.iflag & s_q.ctrl[fetch_seq_pkg::CTRL_IEN_LSB +: 3];
    // No acknowledge with both stack levels used; flag stays latched
    assign take_int = bd && run && !s_q.tbl_stall && !s_q.ir_dummy && !s_q.pcl_pend
                      && s_q.gie && (|ien_hit) && (s_q.depth != fetch_seq_pkg::STACK_DEPTH);
    // A discarded word never executes
    assign exec = bd && run && !s_q.tbl_stall && !take_int && !s_q.ir_dummy;
    assign cls = s_q.ir[13:12];
    assign fn = s_q.ir[11:8];
    assign is_alu = exec && (cls == fetch_seq_pkg::CLS_ALU);
    assign is_branch = exec && (cls == fetch_seq_pkg::CLS_BRANCH);
    assign is_call = is_branch && (s_q.ir[11:10] == fetch_seq_pkg::BR_CALL);
    assign is_ret = exec && (cls == fetch_seq_pkg::CLS_MISC)
                    && ((fn == fetch_seq_pkg::MI_SUBROUTINE_RETURN)
                        || (fn == fetch_seq_pkg::MI_INTERRUPT_RETURN));
    assign is_skip = exec && (cls == fetch_seq_pkg::CLS_MISC)
                     && (((fn == fetch_seq_pkg::MI_SKIP_ZERO) && (s_q.acc == 8'h00))
                         || ((fn == fetch_seq_pkg::MI_SKIP_NONZERO) && (s_q.acc != 8'h00)));
    assign is_tbl = exec && (cls == fetch_seq_pkg::CLS_MISC)
                    && ((fn == fetch_seq_pkg::MI_TABLE_READ_CURRENT_PAGE)
                        || (fn == fetch_seq_pkg::MI_TABLE_READ_LAST_PAGE));

    always_comb
    begin
        logic [9:0] pc_next;
        logic [9:0] tbl_addr;
        logic [9:0] push_val;
        logic push;
        logic [2:0] clr;
        fetch_seq_pkg::alu_out_s ao;
        s_d = s_q;
        pc_next = s_q.pc + 10'h001;
        tbl_addr = {s_q.pc[9:8], s_q.tblp};
        push_val = s_q.pc;
        push = 1'b0;
        clr = 3'h0;
        ao = alu(fn, s_q.acc, s_q.ir[7:0], s_q.status);
        s_d.phase = s_q.phase + 2'h1;
        s_d.phase_clk = {s_q.phase_clk[2:0], s_q.phase_clk[3]};
        s_d.int_ack = 1'b0;
        s_d.rdata = 8'h00;
        if (bd && run)
        begin
            if (s_q.tbl_stall)
            begin
                // Second table cycle: word arrives, sequencing resumes
                s_d.tbl_stall = 1'b0;
                s_d.acc = PM_DATA[7:0];
                s_d.table_high_byte = PM_DATA[13:8];
                s_d.pm_addr = s_q.pc;
            end
            else if (take_int)
            begin
                // Word in hand has not run yet, so it is the return point
                push = 1'b1;
                push_val = s_q.pc - 10'h001;
                s_d.gie = 1'b0;
                s_d.int_ack = 1'b1;
                s_d.ir_dummy = 1'b1;
                if (ien_hit[0])
                begin
                    pc_next = fetch_seq_pkg::VEC_EXT;
                    clr = 3'h1;
                end
                else if (ien_hit[1])
                begin
                    pc_next = fetch_seq_pkg::VEC_TMR;
                    clr = 3'h2;
                end
                else
                begin
                    pc_next = fetch_seq_pkg::VEC_ADC;
                    clr = 3'h4;
                end
                s_d.pc = pc_next;
                s_d.pm_addr = pc_next;
            end
            else
            begin
                // Latch the word fetched this cycle while the current one runs
                s_d.ir = PM_DATA;
                s_d.ir_dummy = 1'b0;
                if (is_alu)
                begin
                    s_d.acc = ao.res;
                    s_d.status = ao.status;
                end
                if (is_branch)
                begin
                    pc_next = s_q.ir[9:0];
                    s_d.ir_dummy = 1'b1;
                    push = is_call;
                end
                if (is_ret)
                begin
                    pc_next = (s_q.depth == fetch_seq_pkg::STACK_DEPTH) ? s_q.stk1 : s_q.stk0;
                    s_d.ir_dummy = 1'b1;
                    if (s_q.depth != 2'h0)
                    begin
                        s_d.depth = s_q.depth - 2'h1;
                    end
                    if (fn == fetch_seq_pkg::MI_INTERRUPT_RETURN)
                    begin
                        s_d.gie = 1'b1;
                    end
                end
                if (is_skip)
                begin
                    s_d.ir_dummy = 1'b1;
                end
                if (exec && (cls == fetch_seq_pkg::CLS_MISC))
                begin
                    if (fn == fetch_seq_pkg::MI_WRITE_PC_LOW)
                    begin
                        pc_next = {s_q.pc[9:8], s_q.ir[7:0]};
                        s_d.ir_dummy = 1'b1;
                    end
                    if (fn == fetch_seq_pkg::MI_SET_TABLE_PTR)
                    begin
                        s_d.tblp = s_q.ir[7:0];
                    end
                    if (fn == fetch_seq_pkg::MI_TABLE_READ_LAST_PAGE)
                    begin
                        tbl_addr = {fetch_seq_pkg::LAST_PAGE, s_q.tblp};
                    end
                end
                if (s_q.pcl_pend)
                begin
                    // Software write overrides the flow; page bits are kept
                    pc_next = {s_q.pc[9:8], s_q.pcl_val};
                    s_d.ir_dummy = 1'b1;
                    s_d.pcl_pend = 1'b0;
                end
                s_d.pc = pc_next;
                s_d.tbl_stall = is_tbl;
                s_d.pm_addr = is_tbl ? tbl_addr : pc_next;
            end
        end
        if (push)
        begin
            // Two levels only, not visible on the register port
            // Full stack: top entry is overwritten, the oldest survives
            if (s_q.depth == 2'h0)
            begin
                s_d.stk0 = push_val;
                s_d.depth = 2'h1;
            end
            else
            begin
                s_d.stk1 = push_val;
                s_d.depth = fetch_seq_pkg::STACK_DEPTH;
            end
        end
        // New request wins over the clear of an acknowledged one
        s_d.iflag = (s_q.iflag & ~clr) | IRQ;
        if (BUS_REQ.rd)
        begin
            unique case (BUS_REQ.addr)
                fetch_seq_pkg::OFS_PC_LOW_BYTE: s_d.rdata = s_q.pc[7:0];
                fetch_seq_pkg::OFS_ACC: s_d.rdata = s_q.acc;
                fetch_seq_pkg::OFS_STATUS: s_d.rdata = {4'h0, s_q.status};
                fetch_seq_pkg::OFS_TABLE_PTR: s_d.rdata = s_q.tblp;
                fetch_seq_pkg::OFS_TABLE_HIGH_BYTE: s_d.rdata = {2'h0, s_q.table_high_byte};
                fetch_seq_pkg::OFS_CTRL: s_d.rdata = {4'h0, s_q.ctrl};
                fetch_seq_pkg::OFS_INT_FLAGS: s_d.rdata = {5'h00, s_q.iflag};
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (BUS_REQ.wr)
        begin
            unique case (BUS_REQ.addr)
                fetch_seq_pkg::OFS_PC_LOW_BYTE:
                begin
                    s_d.pcl_pend = 1'b1;
                    s_d.pcl_val = BUS_REQ.wdata;
                end
                fetch_seq_pkg::OFS_ACC: s_d.acc = BUS_REQ.wdata;
                fetch_seq_pkg::OFS_TABLE_PTR: s_d.tblp = BUS_REQ.wdata;
                fetch_seq_pkg::OFS_CTRL: s_d.ctrl = BUS_REQ.wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s_q <= '0;
            s_q.phase_clk <= fetch_seq_pkg::PHASE_CLK_RST;
            s_q.pc <= fetch_seq_pkg::VEC_RESET;
            s_q.pm_addr <= fetch_seq_pkg::VEC_RESET;
            s_q.ir_dummy <= 1'b1;
            s_q.depth <= 2'h0;
            s_q.ctrl <= fetch_seq_pkg::CTRL_RST;
            s_q.gie <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    assign PM_ADDR = s_q.pm_addr;
    assign INT_ACK = s_q.int_ack;
    assign PHASE_CLOCKS = s_q.phase_clk;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);

    phase_onehot_a: assert property ($onehot(PHASE_CLOCKS))
        else $error("phase clocks not one-hot");
    phase_ring_a: assert property (PHASE_CLOCKS[3] |=> PHASE_CLOCKS[0])
        else $error("phase clocks not a ring");
    fetch_hold_a: assert property (PHASE_CLOCKS[0] |-> ##1 $stable(PM_ADDR) [*3])
        else $error("fetch address moved inside an instruction cycle");
    pc_inc_a: assert property (is_alu && !s_q.pcl_pend |=> (s_q.pc == $past(s_q.pc) + 10'h001))
        else $error("counter did not step by one");
    branch_two_a: assert property (is_branch |=> s_q.ir_dummy ##4 !s_q.ir_dummy)
        else $error("branch did not take exactly two cycles");
    skip_dummy_a: assert property (is_skip |=> (s_q.ir_dummy && !exec) [*4])
        else $error("skipped word was not discarded");
    pcl_page_a: assert property (bd && run && s_q.pcl_pend && !s_q.tbl_stall && !take_int
                                 |=> s_q.ir_dummy && (s_q.pc[9:8] == $past(s_q.pc[9:8])))
        else $error("low byte write left page or skipped dummy");
    int_block_a: assert property (bd && (s_q.depth == fetch_seq_pkg::STACK_DEPTH)
                                  |=> !INT_ACK)
        else $error("interrupt taken with full stack");
    int_vector_a: assert property (take_int |=> INT_ACK && (s_q.depth != 2'h0)
                                   && (s_q.pc[9:4] == 6'h00))
        else $error("interrupt did not push and vector");
    call_push_a: assert property (is_call && (s_q.depth != 2'h2)
                                  |=> s_q.depth == $past(s_q.depth) + 2'h1)
        else $error("call did not push");
    tbl_two_a: assert property (is_tbl |=> s_q.tbl_stall [*4] ##1 !s_q.tbl_stall)
        else $error("table read not two cycles");
    dummy_quiet_a: assert property (bd && s_q.ir_dummy && !BUS_REQ.wr |=> $stable(s_q.status))
        else $error("dummy cycle changed status");

endmodule : mcu_fetch_sequencer

`default_nettype wire

/* File: include/fetch_seq_pkg.sv */
package fetch_seq_pkg;

    // Widths
    localparam int PC_W = 10;
    localparam int WORD_W = 14;
    localparam int PHASES = 4;

    // Register map, one byte per index on the plain port
    localparam logic [3:0] OFS_PC_LOW_BYTE = 4'h0;
    localparam logic [3:0] OFS_ACC = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_TABLE_PTR = 4'h3;
    localparam logic [3:0] OFS_TABLE_HIGH_BYTE = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h5;
    localparam logic [3:0] OFS_INT_FLAGS = 4'h6;

    // Control register fields and reset values
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_IEN_LSB = 1;
    localparam logic [3:0] CTRL_RST = 4'h1;
    localparam logic [3:0] PHASE_CLK_RST = 4'h1;

    // Status register fields
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;

    // Vectors: reset, external edge, timer overflow, conversion complete
    localparam logic [9:0] VEC_RESET = 10'h000;
    localparam logic [9:0] VEC_EXT = 10'h004;
    localparam logic [9:0] VEC_TMR = 10'h008;
    localparam logic [9:0] VEC_ADC = 10'h00C;
    localparam logic [1:0] LAST_PAGE = 2'h3;
    localparam logic [1:0] STACK_DEPTH = 2'h2;

    // Instruction classes in bits 13:12
    localparam logic [1:0] CLS_ALU = 2'h0;
    localparam logic [1:0] CLS_BRANCH = 2'h1;
    localparam logic [1:0] CLS_MISC = 2'h2;

    // Branch class, bits 11:10
    localparam logic [1:0] BR_JUMP_OP = 2'h0;
    localparam logic [1:0] BR_CALL = 2'h1;

    // Miscellaneous class, bits 11:8
    localparam logic [3:0] MI_SUBROUTINE_RETURN = 4'h0;
    localparam logic [3:0] MI_INTERRUPT_RETURN = 4'h1;
    localparam logic [3:0] MI_SKIP_ZERO = 4'h2;
    localparam logic [3:0] MI_SKIP_NONZERO = 4'h3;
    localparam logic [3:0] MI_WRITE_PC_LOW = 4'h4;
    localparam logic [3:0] MI_SET_TABLE_PTR = 4'h5;
    localparam logic [3:0] MI_TABLE_READ_CURRENT_PAGE = 4'h6;
    localparam logic [3:0] MI_TABLE_READ_LAST_PAGE = 4'h7;

    // ALU functions, bits 11:8 of the ALU class
    localparam logic [3:0] AF_ADD = 4'h0;
    localparam logic [3:0] AF_ADC = 4'h1;
    localparam logic [3:0] AF_SUB = 4'h2;
    localparam logic [3:0] AF_SBC = 4'h3;
    localparam logic [3:0] AF_DAA = 4'h4;
    localparam logic [3:0] AF_AND = 4'h5;
    localparam logic [3:0] AF_OR = 4'h6;
    localparam logic [3:0] AF_XOR = 4'h7;
    localparam logic [3:0] AF_CPL = 4'h8;
    localparam logic [3:0] AF_RR = 4'h9;
    localparam logic [3:0] AF_RRC = 4'hA;
    localparam logic [3:0] AF_RL = 4'hB;
    localparam logic [3:0] AF_RLC = 4'hC;
    localparam logic [3:0] AF_INC = 4'hD;
    localparam logic [3:0] AF_DEC = 4'hE;
    localparam logic [3:0] AF_MOV = 4'hF;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic [7:0] res;
        logic [3:0] status;
    } alu_out_s;

endpackage : fetch_seq_pkg

/* File: testbench/pm_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pm_model (
    input wire logic [9:0] PM_ADDR, // Word address from the sequencer
    output logic [13:0] PM_DATA // Word at that address
);
    logic [13:0] mem [0:1023];

    initial
    begin
        // Unused words are no-ops so a stray fetch cannot disturb the run
        for (int i = 0; i < 1024; i++)
        begin
            mem[i] = 14'h3000;
        end
        mem[10'h000] = 14'h0F00;
        mem[10'h001] = 14'h2200;
        // Of these, words 002, 006, 022 and 142 are fetched but must never take effect
        mem[10'h002] = 14'h0F55;
        mem[10'h003] = 14'h0001;
        mem[10'h004] = 14'h1420;
        mem[10'h005] = 14'h1140;
        mem[10'h006] = 14'h0FEE;
        mem[10'h020] = 14'h0010;
        mem[10'h021] = 14'h2000;
        mem[10'h022] = 14'h0F99;
        mem[10'h140] = 14'h2441;
        mem[10'h141] = 14'h2441;
        mem[10'h142] = 14'h0F33;
        mem[10'h180] = 14'h0FFF;
        mem[10'h181] = 14'h0001;
        mem[10'h182] = 14'h2506;
        mem[10'h183] = 14'h2700;
        mem[10'h185] = 14'h1185;
        mem[10'h306] = 14'h2A5B;
    end

    // Memory answers within the same cycle, as the fetch path expects
    assign PM_DATA = mem[PM_ADDR];

endmodule : pm_model
`default_nettype wire

/* File: testbench/tb_mcu_fetch_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_mcu_fetch_sequencer;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    fetch_seq_pkg::bus_req_s bus_req = '0;
    logic [7:0] rdata;
    logic [9:0] pm_addr;
    logic [13:0] pm_data;
    logic [2:0] irq = 3'h0;
    logic int_ack;
    logic [3:0] phase_clocks;
    int num_errors = 0;
    int total_checks = 0;
    int acks;
    logic [9:0] trace_q [$];
    logic [9:0] exp_trace [16] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005,
        10'h020, 10'h021, 10'h022, 10'h005, 10'h006, 10'h140, 10'h141, 10'h141, 10'h142,
        10'h141};

    always #20 core_clk = ~core_clk;

    mcu_fetch_sequencer dut_u (
        .CORE_CLK(core_clk),
        .ARST_N(arst_n),
        .BUS_REQ(bus_req),
        .RDATA(rdata),
        .PM_ADDR(pm_addr),
        .PM_DATA(pm_data),
        .IRQ(irq),
        .INT_ACK(int_ack),
        .PHASE_CLOCKS(phase_clocks)
    );

    pm_model pm_u (
        .PM_ADDR(pm_addr),
        .PM_DATA(pm_data)
    );

    // Fetch address of the first 16 instruction cycles, taken at the edge that ends each fetch phase
    always @(posedge core_clk)
    begin
        if (arst_n === 1'b1 && phase_clocks[0] === 1'b1 && trace_q.size() < 16)
        begin
            trace_q.push_back(pm_addr);
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic bus_write(input logic [3:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask : bus_write

    task automatic expect_reg(input string what, input logic [3:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        check(what, rdata, exp);
    endtask : expect_reg

    // Bounded wait; running out ends the run as a failure
    task automatic wait_addr(input logic [9:0] target);
        for (int i = 0; i < 400; i++)
        begin
            @(posedge core_clk);
            if (pm_addr === target)
            begin
                return;
            end
        end
        check("pm_addr", pm_addr, target);
        results();
    endtask : wait_addr

    task automatic pulse_irq(input logic [2:0] bits);
        @(posedge core_clk);
        irq <= bits;
        @(posedge core_clk);
        irq <= 3'h0;
    endtask : pulse_irq

    initial
    begin
        repeat (6) @(posedge core_clk);
        check("phase_clocks", phase_clocks, 4'h1);
        check("pm_addr", pm_addr, 10'h000);
        check("rdata", rdata, 8'h00);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            #1;
            check("phase_clocks", phase_clocks, 4'(4'h1 << ((i + 1) % 4)));
        end
        for (int i = 0; i < 200 && trace_q.size() < 16; i++)
        begin
            @(posedge core_clk);
        end
        check("trace_len", trace_q.size(), 16);
        for (int i = 0; i < 16 && i < trace_q.size(); i++)
        begin
            check("fetch", trace_q[i], exp_trace[i]);
        end
        expect_reg("acc", fetch_seq_pkg::OFS_ACC, 8'h11);
        expect_reg("status", fetch_seq_pkg::OFS_STATUS, 8'h00);
        // A jump by low-byte write must stay inside the current page
        bus_write(fetch_seq_pkg::OFS_PC_LOW_BYTE, 8'h80);
        wait_addr(10'h180);
        wait_addr(10'h185);
        repeat (16) @(posedge core_clk);
        expect_reg("acc", fetch_seq_pkg::OFS_ACC, 8'h5B);
        expect_reg("tbl_high", fetch_seq_pkg::OFS_TABLE_HIGH_BYTE, 8'h2A);
        expect_reg("status", fetch_seq_pkg::OFS_STATUS, 8'h07);
        bus_write(fetch_seq_pkg::OFS_STATUS, 8'h00);
        expect_reg("status", fetch_seq_pkg::OFS_STATUS, 8'h07);
        expect_reg("unmapped", 4'h9, 8'h00);
        // Only the edge source is enabled; a conversion request must wait
        bus_write(fetch_seq_pkg::OFS_CTRL, 8'h03);
        pulse_irq(3'h4);
        acks = 0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge core_clk);
            #1;
            if (int_ack === 1'b1)
            begin
                acks++;
            end
        end
        check("masked_acks", acks, 0);
        expect_reg("int_flags", fetch_seq_pkg::OFS_INT_FLAGS, 8'h04);
        pulse_irq(3'h1);
        acks = 0;
        for (int i = 0; i < 40 && acks == 0; i++)
        begin
            @(posedge core_clk);
            #1;
            if (int_ack === 1'b1)
            begin
                acks = 1;
                check("vector", pm_addr, fetch_seq_pkg::VEC_EXT);
            end
        end
        check("ack_seen", acks, 1);
        results();
    end

endmodule : tb_mcu_fetch_sequencer
`default_nettype wire
